//--- hdl/gpio_bc_map.svh
/*
  Register offsets, field positions, reset values and widths of the two-port GPIO block.
  Assumes a 32-bit classic Wishbone bus with one register per aligned word.
*/
`ifndef GPIO_BC_MAP_SVH
`define GPIO_BC_MAP_SVH

// ==========================================================
// Register byte offsets
`define OFS_PIN_VALUE_B 8'h00
`define OFS_OUTPUT_LATCH_B 8'h04
`define OFS_DIRECTION_B 8'h08
`define OFS_INT_CTRL_MAIN 8'h0C
`define OFS_INT_CTRL_SECOND 8'h10
`define OFS_INT_CTRL_THIRD 8'h14
`define OFS_ANALOG_PIN_CFG 8'h18
`define OFS_PIN_VALUE_C 8'h1C
`define OFS_OUTPUT_LATCH_C 8'h20
`define OFS_DIRECTION_C 8'h24

// ==========================================================
// Field positions
`define BIT_PORT_CHANGE_FLAG 0
`define BIT_PORT_CHANGE_IRQ_EN 3
`define BIT_PULLUP_ENABLE_N 7
`define BIT_PORT_CHANGE_PRIO 0

// ==========================================================
// Reset values
`define RST_DIRECTION 8'hFF
`define RST_LATCH 8'h00
`define RST_INT_CTRL_MAIN 8'h00
`define RST_INT_CTRL_SECOND 8'h80
`define RST_INT_CTRL_THIRD 8'h00
`define RST_ANALOG_ALL 5'h1F
`define RST_ANALOG_NONE 5'h00
`define RST_SETTLE 3'h7

`endif

//--- hdl/gpio_bc_pkg.sv
/*
  Shared types of the two-port GPIO block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gpio_bc_pkg;
  typedef logic [7:0] port_t;
  typedef logic [3:0] change_t;
  typedef logic [4:0] analog_t;
endpackage : gpio_bc_pkg

//--- hdl/pin_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the pins change freely with respect to clk_i.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] pin_i, // Raw pin levels
  output logic [WIDTH-1:0] pin_o // Synchronised levels
);
  logic [WIDTH-1:0] first_reg;
  logic [WIDTH-1:0] second_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_reg <= '0;
      second_reg <= '0;
    end else begin
      first_reg <= pin_i;
      second_reg <= first_reg;
    end
  end

  assign pin_o = second_reg;
endmodule : pin_sync

//--- hdl/change_detect.sv
/*
  Change comparison on the four upper pins of the second port with a sticky flag.
  Assumes synchronised pins and a one-cycle refresh pulse from the register slave.
*/
`timescale 1ns/1ns
`include "gpio_bc_map.svh"
module change_detect (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire gpio_bc_pkg::change_t pin_i, // Synchronised upper pins
  input wire gpio_bc_pkg::change_t take_part_i, // Pins that join the comparison
  input wire logic refresh_i, // Port access: take a new snapshot
  input wire logic clear_i, // Software clears the flag
  output logic mismatch_o, // Any participating pin differs
  output logic flag_o // Sticky port-change flag
);
  gpio_bc_pkg::change_t snap_reg;
  logic flag_reg;
  logic flag_next;
  logic [2:0] settle_reg;
  logic settling;

  // Snapshot follows the pins until the synchroniser has filled, so reset raises no false change
  assign settling = |settle_reg;
  assign mismatch_o = ~settling & (|((pin_i ^ snap_reg) & take_part_i));
  // A standing mismatch sets the flag again, so set wins over clear
  assign flag_next = mismatch_o | (flag_reg & ~clear_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_reg <= '0;
      flag_reg <= 1'b0;
      settle_reg <= `RST_SETTLE;
    end else begin
      settle_reg <= {settle_reg[1:0], 1'b0};
      if (refresh_i || settling) begin
        snap_reg <= pin_i;
      end
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule : change_detect

//--- hdl/gpio_port_bc.sv
/*
  Two 8-bit bidirectional ports with direction, latch and pin-read paths, weak pull-ups,
  analog defaults and change detection on the second port, and peripheral overrides.
  Assumes a classic Wishbone master, pins synchronous-free and configuration straps stable
  while reset is high.
*/
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ns
`include "gpio_bc_map.svh"

module gpio_port_bc (
  input wire logic clk_i, // System clock, 250 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic move_dest_i, // Access is a memory_to_memory_move destination
  input wire logic analog_default_cfg_i, // Strap: B4..B0 analog at reset
  input wire logic capture2_pin_select_i, // Strap: 0 puts channel 2 on B3
  input wire logic debug_en_i, // Programming or debug enabled
  input wire gpio_bc_pkg::port_t pin_b_i, // Port B pin levels
  output gpio_bc_pkg::port_t pin_b_o, // Port B drive value
  output gpio_bc_pkg::port_t pin_b_oe_o, // Port B drive enable
  output gpio_bc_pkg::port_t pullup_b_o, // Port B weak pull-up on
  input wire gpio_bc_pkg::port_t pin_c_i, // Port C pin levels
  output gpio_bc_pkg::port_t pin_c_o, // Port C drive value
  output gpio_bc_pkg::port_t pin_c_oe_o, // Port C drive enable
  input wire gpio_bc_pkg::port_t periph_c_force_out_i, // Peripheral forces C pin out
  input wire gpio_bc_pkg::port_t periph_c_force_in_i, // Peripheral forces C pin in
  input wire gpio_bc_pkg::port_t periph_c_data_en_i, // Peripheral owns C pin data
  input wire gpio_bc_pkg::port_t periph_c_data_i, // Peripheral C pin data
  input wire logic capture2_out_en_i, // Channel 2 drives its output
  input wire logic capture2_data_i, // Channel 2 output data
  output logic capture2_in_o, // Channel 2 capture input
  input wire logic comparator1_route_i, // Comparator 1 routed to B5
  input wire logic comparator1_output_i, // Comparator 1 output level
  input wire logic program_data_oe_i, // Debug drives program data pin
  input wire logic program_data_i, // Debug program data out
  output logic program_clock_pin_o, // Program clock seen on B6
  output logic program_data_pin_o, // Program data seen on B7
  output logic wake_o // Port-change wake request
);
  // ==========================================================
  // Registers
  gpio_bc_pkg::port_t output_latch_b_reg;
  gpio_bc_pkg::port_t direction_b_reg;
  gpio_bc_pkg::port_t output_latch_c_reg;
  gpio_bc_pkg::port_t direction_c_reg;
  gpio_bc_pkg::port_t int_main_reg;
  gpio_bc_pkg::port_t int_second_reg;
  gpio_bc_pkg::port_t int_third_reg;
  gpio_bc_pkg::analog_t analog_b_reg;
  logic capture2_sel_reg;
  logic [31:0] dat_o_reg;
  logic ack_reg;
  gpio_bc_pkg::port_t pin_b_o_reg;
  gpio_bc_pkg::port_t pin_b_oe_reg;
  gpio_bc_pkg::port_t pullup_b_reg;
  gpio_bc_pkg::port_t pin_c_o_reg;
  gpio_bc_pkg::port_t pin_c_oe_reg;
  logic capture2_in_reg;
  logic prog_clk_reg;
  logic prog_dat_reg;
  logic wake_reg;

  // ==========================================================
  // Pin synchronisers
  gpio_bc_pkg::port_t sync_b;
  gpio_bc_pkg::port_t sync_c;

  pin_sync #(.WIDTH(8)) u_sync_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_b_i),
    .pin_o(sync_b)
  );

  pin_sync #(.WIDTH(8)) u_sync_c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_c_i),
    .pin_o(sync_c)
  );

  // ==========================================================
  // Bus decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  wire req = cyc_i & stb_i & ~ack_reg;
  wire wr_lo = req & we_i & sel_i[0];
  wire rd = req & ~we_i;
  wire wr_pin_b = wr_lo & hit(adr_i, `OFS_PIN_VALUE_B);
  wire wr_latch_b = wr_lo & hit(adr_i, `OFS_OUTPUT_LATCH_B);
  wire wr_dir_b = wr_lo & hit(adr_i, `OFS_DIRECTION_B);
  wire wr_main = wr_lo & hit(adr_i, `OFS_INT_CTRL_MAIN);
  wire wr_second = wr_lo & hit(adr_i, `OFS_INT_CTRL_SECOND);
  wire wr_third = wr_lo & hit(adr_i, `OFS_INT_CTRL_THIRD);
  wire wr_analog = wr_lo & hit(adr_i, `OFS_ANALOG_PIN_CFG);
  wire wr_pin_c = wr_lo & hit(adr_i, `OFS_PIN_VALUE_C);
  wire wr_latch_c = wr_lo & hit(adr_i, `OFS_OUTPUT_LATCH_C);
  wire wr_dir_c = wr_lo & hit(adr_i, `OFS_DIRECTION_C);
  wire pin_b_access = req & hit(adr_i, `OFS_PIN_VALUE_B) & (~we_i | sel_i[0]);
  // A move into the port leaves the snapshot alone so a pending change survives
  wire refresh = pin_b_access & ~(we_i & move_dest_i);
  wire clear_flag = wr_main & ~dat_i[`BIT_PORT_CHANGE_FLAG];

  // ==========================================================
  // Port B pin paths
  wire gpio_bc_pkg::port_t analog_b = {3'b000, analog_b_reg};
  wire gpio_bc_pkg::port_t debug_b = {debug_en_i, debug_en_i, 6'h00};
  // Analog and debug pins read zero on the digital path
  wire gpio_bc_pkg::port_t read_b = sync_b & ~analog_b & ~debug_b;
  wire pullups_on = ~int_second_reg[`BIT_PULLUP_ENABLE_N];
  wire cap2_on_b = ~capture2_sel_reg;
  gpio_bc_pkg::port_t drive_b;
  gpio_bc_pkg::port_t oe_b;
  gpio_bc_pkg::port_t pull_b;

  // Peripheral data takes priority over latch data on its pin
  always_comb begin
    drive_b = output_latch_b_reg;
    oe_b = ~direction_b_reg;
    if (cap2_on_b && capture2_out_en_i) begin
      drive_b[3] = capture2_data_i;
    end
    if (comparator1_route_i) begin
      drive_b[5] = comparator1_output_i;
    end
    if (debug_en_i) begin
      oe_b[6] = 1'b0;
      oe_b[7] = program_data_oe_i;
      drive_b[7] = program_data_i;
    end
    pull_b = {8{pullups_on}} & direction_b_reg & ~debug_b;
  end

  // ==========================================================
  // Change detection on B7..B4
  wire gpio_bc_pkg::change_t take_part = direction_b_reg[7:4] & ~debug_b[7:4];
  logic mismatch;
  logic change_flag;

  change_detect u_change (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(sync_b[7:4]),
    .take_part_i(take_part),
    .refresh_i(refresh),
    .clear_i(clear_flag),
    .mismatch_o(mismatch),
    .flag_o(change_flag)
  );

  // Wake request is the flag gated by the port-change interrupt enable, registered on clk_i
  wire wake_next = change_flag & int_main_reg[`BIT_PORT_CHANGE_IRQ_EN];

  // ==========================================================
  // Port C pin paths
  gpio_bc_pkg::port_t c_own_data;
  gpio_bc_pkg::port_t c_own_en;
  always_comb begin
    c_own_data = periph_c_data_i;
    c_own_en = periph_c_data_en_i;
    if (!cap2_on_b && capture2_out_en_i) begin
      c_own_en[1] = 1'b1;
      c_own_data[1] = capture2_data_i;
    end
  end
  wire gpio_bc_pkg::port_t drive_c = (c_own_en & c_own_data) | (~c_own_en & output_latch_c_reg);
  // Forced output beats forced input, which beats the direction bit
  wire gpio_bc_pkg::port_t oe_c = periph_c_force_out_i | (~periph_c_force_in_i & ~direction_c_reg);

  // ==========================================================
  // Read data
  gpio_bc_pkg::port_t rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit(adr_i, `OFS_PIN_VALUE_B)) rd_byte = read_b;
    if (hit(adr_i, `OFS_OUTPUT_LATCH_B)) rd_byte = output_latch_b_reg;
    if (hit(adr_i, `OFS_DIRECTION_B)) rd_byte = direction_b_reg;
    if (hit(adr_i, `OFS_INT_CTRL_MAIN)) rd_byte = {int_main_reg[7:1], change_flag};
    if (hit(adr_i, `OFS_INT_CTRL_SECOND)) rd_byte = int_second_reg;
    if (hit(adr_i, `OFS_INT_CTRL_THIRD)) rd_byte = int_third_reg;
    if (hit(adr_i, `OFS_ANALOG_PIN_CFG)) rd_byte = {3'h0, analog_b_reg};
    if (hit(adr_i, `OFS_PIN_VALUE_C)) rd_byte = sync_c;
    if (hit(adr_i, `OFS_OUTPUT_LATCH_C)) rd_byte = output_latch_c_reg;
    if (hit(adr_i, `OFS_DIRECTION_C)) rd_byte = direction_c_reg;
  end

  // ==========================================================
  // Bus slave and registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (rd) begin
        dat_o_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Straps are sampled while reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture2_sel_reg <= capture2_pin_select_i;
      analog_b_reg <= analog_default_cfg_i ? `RST_ANALOG_ALL : `RST_ANALOG_NONE;
    end else if (wr_analog) begin
      analog_b_reg <= dat_i[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_latch_b_reg <= `RST_LATCH;
      direction_b_reg <= `RST_DIRECTION;
      output_latch_c_reg <= `RST_LATCH;
      direction_c_reg <= `RST_DIRECTION;
    end else begin
      if (wr_pin_b || wr_latch_b) output_latch_b_reg <= dat_i[7:0];
      if (wr_dir_b) direction_b_reg <= dat_i[7:0];
      if (wr_pin_c || wr_latch_c) output_latch_c_reg <= dat_i[7:0];
      if (wr_dir_c) direction_c_reg <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_main_reg <= `RST_INT_CTRL_MAIN;
      int_second_reg <= `RST_INT_CTRL_SECOND;
      int_third_reg <= `RST_INT_CTRL_THIRD;
    end else begin
      if (wr_main) int_main_reg <= dat_i[7:0];
      if (wr_second) int_second_reg <= dat_i[7:0];
      if (wr_third) int_third_reg <= dat_i[7:0];
    end
  end

  // ==========================================================
  // Output flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_b_o_reg <= 8'h00;
      pin_b_oe_reg <= 8'h00;
      pullup_b_reg <= 8'h00;
      pin_c_o_reg <= 8'h00;
      pin_c_oe_reg <= 8'h00;
      capture2_in_reg <= 1'b0;
      prog_clk_reg <= 1'b0;
      prog_dat_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      pin_b_o_reg <= drive_b;
      pin_b_oe_reg <= oe_b;
      pullup_b_reg <= pull_b;
      pin_c_o_reg <= drive_c;
      pin_c_oe_reg <= oe_c;
      capture2_in_reg <= cap2_on_b ? sync_b[3] : sync_c[1];
      prog_clk_reg <= debug_en_i & sync_b[6];
      prog_dat_reg <= debug_en_i & sync_b[7];
      wake_reg <= wake_next;
    end
  end

  assign dat_o = dat_o_reg;
  assign ack_o = ack_reg;
  assign pin_b_o = pin_b_o_reg;
  assign pin_b_oe_o = pin_b_oe_reg;
  assign pullup_b_o = pullup_b_reg;
  assign pin_c_o = pin_c_o_reg;
  assign pin_c_oe_o = pin_c_oe_reg;
  assign capture2_in_o = capture2_in_reg;
  assign program_clock_pin_o = prog_clk_reg;
  assign program_data_pin_o = prog_dat_reg;
  assign wake_o = wake_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_dir_drives_b: assert property ($past(!debug_en_i) |-> pin_b_oe_o[1:0] == ~$past(direction_b_reg[1:0]))
    else $error("port B enable does not follow direction");
  a_latch_readback: assert property (rd && hit(adr_i, `OFS_OUTPUT_LATCH_B) |=> ack_o && dat_o[7:0] == $past(output_latch_b_reg))
    else $error("latch read does not return latch");
  a_pin_write_latch: assert property (wr_pin_b |=> output_latch_b_reg == $past(dat_i[7:0]))
    else $error("pin value write did not reach latch");
  a_pullup_output_off: assert property ((pullup_b_o & ~$past(direction_b_reg)) == 8'h00)
    else $error("pull-up on an output pin");
  a_pullup_reset_off: assert property ($past(rst_i) |-> pullup_b_o == 8'h00 ##1 pullup_b_o == 8'h00)
    else $error("pull-up on right after reset");
  a_analog_strap: assert property ($past(rst_i) |-> analog_b_reg == ($past(analog_default_cfg_i) ? 5'h1F : 5'h00))
    else $error("analog default not taken from strap");
  a_mismatch_flag: assert property (mismatch && !clear_flag |=> change_flag ##1 change_flag || !$past(mismatch))
    else $error("mismatch did not set flag");
  a_flag_set_wins: assert property (mismatch && clear_flag |=> change_flag)
    else $error("clear beat a standing mismatch");
  a_cap2_on_b: assert property (!capture2_sel_reg && capture2_out_en_i |=> pin_b_o[3] == $past(capture2_data_i))
    else $error("channel 2 not on B3");
  a_comparator_b5: assert property (comparator1_route_i |=> pin_b_o[5] == $past(comparator1_output_i))
    else $error("comparator 1 not on B5");
  a_debug_pins: assert property (debug_en_i |=> !pin_b_oe_o[6] && pullup_b_o[7:6] == 2'b00)
    else $error("debug pins keep other functions");
  a_force_out_c: assert property (periph_c_force_out_i[2] |=> pin_c_oe_o[2])
    else $error("peripheral force-out ignored");
  a_force_in_c: assert property (periph_c_force_in_i[1] && !periph_c_force_out_i[1] |=> !pin_c_oe_o[1])
    else $error("peripheral force-in ignored");
  a_analog_zero: assert property (rd && hit(adr_i, `OFS_PIN_VALUE_B)
    |=> (dat_o[4:0] & $past(analog_b_reg)) == 5'h00)
    else $error("analog pin read not zero");
  a_wake_follows: assert property (change_flag && int_main_reg[`BIT_PORT_CHANGE_IRQ_EN] |=> wake_o)
    else $error("enabled change flag did not wake");
  a_pullup_global: assert property (int_second_reg[`BIT_PULLUP_ENABLE_N] |=> pullup_b_o == 8'h00)
    else $error("pull-up on while globally disabled");
  a_latch_c_write: assert property (wr_latch_c |=> output_latch_c_reg == $past(dat_i[7:0]))
    else $error("port C latch write lost");
endmodule : gpio_port_bc

//--- verif/pin_partner.sv
/*
  Far-side model: the outside circuits wired to one 8-bit port.
  Assumes the bench chooses what the outside world drives and when.
*/
`timescale 1ns/1ns
module pin_partner (
  input wire logic clk_i, // System clock
  input wire gpio_bc_pkg::port_t out_i, // Device drive value
  input wire gpio_bc_pkg::port_t oe_i, // Device drive enable
  input wire gpio_bc_pkg::port_t pullup_i, // Device weak pull-up on
  input wire gpio_bc_pkg::port_t ext_i, // Outside drive value
  input wire gpio_bc_pkg::port_t ext_en_i, // Outside drive enable
  output gpio_bc_pkg::port_t pin_o // Resolved pin level
);
  // ==========================================================
  // Pin resolution
  // Undriven pins without pull-up wander, so a stale level never passes for a driven one
  gpio_bc_pkg::port_t float_reg = 8'h5A;
  always @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & (pullup_i | float_reg));
endmodule : pin_partner

//--- verif/tb.sv
/*
  Self-checking bench for the two-port GPIO block.
  Assumes the pin_partner far-side model and a 250 MHz system clock.
*/
`timescale 1ns/1ns
`include "gpio_bc_map.svh"
module tb;
  typedef struct {bit chk; logic [7:0] val;} exp_s;
  exp_s exp_q[$];
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000;
  logic [3:0] sel = 4'h0;
  logic mv = 1'b0, an_cfg = 1'b1, cap_sel = 1'b1, dbg = 1'b0, cmp_rt = 1'b0, cmp_out = 1'b0;
  logic cap_oe = 1'b0, cap_dat = 1'b0, pd_oe = 1'b0, pd_dat = 1'b0;
  gpio_bc_pkg::port_t ext_b = 8'hFF, ext_b_en = 8'hFF, ext_c = 8'h00, ext_c_en = 8'hFF;
  gpio_bc_pkg::port_t f_out = 8'h00, f_in = 8'h00, c_den = 8'h00, c_dat = 8'h00;
  gpio_bc_pkg::port_t pb_in, pb_o, pb_oe, pb_pu, pc_in, pc_o, pc_oe;
  logic [31:0] dat_o;
  logic ack_o, cap_in, program_clock_pin, program_data_pin, wake;
  logic [7:0] r;
  logic [7:0] rst_adr [8] = '{8'h08, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24, 8'h28};
  logic [7:0] rst_val [8] = '{8'hFF, 8'h00, 8'h00, 8'h80, 8'h00, 8'h1F, 8'hFF, 8'h00};

  gpio_port_bc dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .move_dest_i(mv), .analog_default_cfg_i(an_cfg),
    .capture2_pin_select_i(cap_sel), .debug_en_i(dbg), .pin_b_i(pb_in), .pin_b_o(pb_o), .pin_b_oe_o(pb_oe),
    .pullup_b_o(pb_pu), .pin_c_i(pc_in), .pin_c_o(pc_o), .pin_c_oe_o(pc_oe), .periph_c_force_out_i(f_out),
    .periph_c_force_in_i(f_in), .periph_c_data_en_i(c_den), .periph_c_data_i(c_dat),
    .capture2_out_en_i(cap_oe), .capture2_data_i(cap_dat), .capture2_in_o(cap_in), .comparator1_route_i(cmp_rt),
    .comparator1_output_i(cmp_out), .program_data_oe_i(pd_oe), .program_data_i(pd_dat),
    .program_clock_pin_o(program_clock_pin), .program_data_pin_o(program_data_pin), .wake_o(wake)
  );
  pin_partner part_b (.clk_i(clk_i), .out_i(pb_o), .oe_i(pb_oe), .pullup_i(pb_pu), .ext_i(ext_b),
    .ext_en_i(ext_b_en), .pin_o(pb_in));
  pin_partner part_c (.clk_i(clk_i), .out_i(pc_o), .oe_i(pc_oe), .pullup_i(8'h00), .ext_i(ext_c),
    .ext_en_i(ext_c_en), .pin_o(pc_in));

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic cycle; the request stands until ack is sampled high
  task automatic wb(input bit w, input logic [7:0] a, input logic [7:0] d, input bit chk, input logic [7:0] e);
    exp_q.push_back('{chk, e});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    sel <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 1'b0, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, 1'b1, e);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic wait_wake(input logic v);
    for (int k = 0; k < 16 && wake !== v; k++) @(posedge clk_i);
    check("wake_o", {7'h00, wake}, {7'h00, v});
  endtask : wait_wake

  task automatic do_reset();
    rst_i <= 1'b1;
    tick(12);
    rst_i <= 1'b0;
    tick(1);
  endtask : do_reset

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // Clock, hang guard and read-data monitor
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end

  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && exp_q.size() > 0) begin
      exp_s e;
      e = exp_q.pop_front();
      if (e.chk) begin
        check("read data", dat_o[7:0], e.val);
        check("read upper", {7'h00, |dat_o[31:8]}, 8'h00);
      end
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(57));
    r = 8'($urandom());
    do_reset();
    check("pullup_b_o", pb_pu, 8'h00);
    check("pin_b_oe_o", pb_oe, 8'h00);
    wr(8'h28, 8'h55);
    for (int i = 0; i < 8; i++) begin
      rd(rst_adr[i], rst_val[i]);
    end
    rd(`OFS_PIN_VALUE_B, 8'hE0);
    wr(`OFS_OUTPUT_LATCH_B, r);
    wr(`OFS_DIRECTION_B, 8'h00);
    check("pin_b_oe_o", pb_oe, 8'hFF);
    check("pin_b_o", pb_o, r);
    tick(2);
    rd(`OFS_PIN_VALUE_B, r & 8'hE0);
    wr(`OFS_ANALOG_PIN_CFG, 8'h00);
    rd(`OFS_PIN_VALUE_B, r);
    cmp_rt <= 1'b1;
    cmp_out <= ~r[5];
    tick(2);
    check("pin_b_o", pb_o, r ^ 8'h20);
    cmp_rt <= 1'b0;
    ext_b <= ~r;
    wr(`OFS_DIRECTION_B, 8'hFF);
    rd(`OFS_OUTPUT_LATCH_B, r);
    rd(`OFS_PIN_VALUE_B, ~r);
    wr(`OFS_PIN_VALUE_B, 8'h3C);
    rd(`OFS_OUTPUT_LATCH_B, 8'h3C);
    wr(`OFS_INT_CTRL_SECOND, 8'h00);
    wr(`OFS_DIRECTION_B, 8'h0F);
    check("pullup_b_o", pb_pu, 8'h0F);
    wr(`OFS_INT_CTRL_SECOND, 8'h80);
    check("pullup_b_o", pb_pu, 8'h00);
    ext_b <= 8'h00;
    wr(`OFS_DIRECTION_B, 8'hF0);
    tick(2);
    rd(`OFS_PIN_VALUE_B, 8'h0C);
    wr(`OFS_INT_CTRL_MAIN, 8'h08);
    rd(`OFS_INT_CTRL_MAIN, 8'h08);
    ext_b <= 8'h80;
    wait_wake(1'b1);
    rd(`OFS_INT_CTRL_MAIN, 8'h09);
    wr(`OFS_INT_CTRL_MAIN, 8'h08);
    rd(`OFS_INT_CTRL_MAIN, 8'h09);
    mv <= 1'b1;
    wr(`OFS_PIN_VALUE_B, 8'h10);
    mv <= 1'b0;
    wr(`OFS_INT_CTRL_MAIN, 8'h08);
    rd(`OFS_INT_CTRL_MAIN, 8'h09);
    rd(`OFS_PIN_VALUE_B, 8'h80);
    wr(`OFS_INT_CTRL_MAIN, 8'h08);
    rd(`OFS_INT_CTRL_MAIN, 8'h08);
    wait_wake(1'b0);
    wr(`OFS_DIRECTION_B, 8'hEF);
    ext_b <= 8'h8F;
    tick(6);
    rd(`OFS_INT_CTRL_MAIN, 8'h08);
    dbg <= 1'b1;
    ext_b <= 8'h4F;
    tick(6);
    check("program_clock_pin_o", {7'h00, program_clock_pin}, 8'h01);
    check("program_data_pin_o", {7'h00, program_data_pin}, 8'h00);
    rd(`OFS_INT_CTRL_MAIN, 8'h08);
    rd(`OFS_PIN_VALUE_B, 8'h1F);
    pd_oe <= 1'b1;
    pd_dat <= 1'b1;
    tick(5);
    check("pin_b_oe_o", pb_oe, 8'h90);
    check("pin_b_o", pb_o, 8'h90);
    check("program_data_pin_o", {7'h00, program_data_pin}, 8'h01);
    dbg <= 1'b0;
    pd_oe <= 1'b0;
    ext_c <= r;
    f_out <= 8'h05;
    tick(2);
    check("pin_c_oe_o", pc_oe, 8'h05);
    wr(`OFS_DIRECTION_C, 8'h00);
    f_in <= 8'h02;
    c_den <= 8'h04;
    c_dat <= 8'h04;
    tick(3);
    check("pin_c_oe_o", pc_oe, 8'hFD);
    check("pin_c_o", pc_o, 8'h04);
    rd(`OFS_PIN_VALUE_C, (r & 8'h02) | 8'h04);
    wr(`OFS_OUTPUT_LATCH_C, ~r);
    rd(`OFS_OUTPUT_LATCH_C, ~r);
    f_out <= 8'h00;
    f_in <= 8'h00;
    c_den <= 8'h00;
    wr(`OFS_DIRECTION_C, 8'hFF);
    tick(4);
    check("capture2_in_o", {7'h00, cap_in}, {7'h00, r[1]});
    cap_oe <= 1'b1;
    cap_dat <= r[1];
    tick(2);
    check("pin_c_o", pc_o, (~r & 8'hFD) | {6'h00, r[1], 1'b0});
    an_cfg <= 1'b0;
    cap_sel <= 1'b0;
    ext_b <= 8'hFF;
    do_reset();
    rd(`OFS_ANALOG_PIN_CFG, 8'h00);
    rd(`OFS_PIN_VALUE_B, 8'hFF);
    check("capture2_in_o", {7'h00, cap_in}, 8'h01);
    ext_b <= 8'hF7;
    tick(4);
    check("capture2_in_o", {7'h00, cap_in}, 8'h00);
    cap_dat <= 1'b1;
    wr(`OFS_DIRECTION_B, 8'hF7);
    check("pin_b_o", pb_o, 8'h08);
    check("pin_b_oe_o", pb_oe, 8'h08);
    test_done();
  end
endmodule : tb
